// [core/pbp_map.vh]
/*
  Constants of the byte-at-a-time PROM programmer: bus and counter widths, address
  limits, fill value and timing counts at a 250 MHz system clock.
  Assumes it is included by bare name from the design files.
*/
// What this block does
// - Host holds both mode selects low, standby low, both prom selects high.
// - Host programs one byte at a time, never page programming.
// - Host programs any address it is given, also above the implemented array.
// - Host supplies all-ones data for unused addresses up to the top.
// - Overwrite pulse lasts between 0.19 and 5.25 milliseconds.
`ifndef PBP_MAP_VH
`define PBP_MAP_VH

`define PBP_AW 17
`define PBP_DW 8
`define PBP_FILL 8'hFF
`define PBP_TOP_ADDR 17'h1_FFFF
`define PBP_TOP_48K 17'h0_BFFF
`define PBP_TOP_32K 17'h0_7FFF
// Clock rate in MHz
`define PBP_CLK_MHZ 250
// Program pulse 200 us typical, within 0.19..0.21 ms
`define PBP_TPW_US 200
`define PBP_TPW_CYC (`PBP_TPW_US * `PBP_CLK_MHZ)
// Overwrite pulse: minimum times the attempts, kept in 0.19..5.25 ms
`define PBP_TOPW_MIN_US 190
`define PBP_TOPW_MIN_CYC (`PBP_TOPW_MIN_US * `PBP_CLK_MHZ)
`define PBP_TOPW_MAX_US 5250
`define PBP_TOPW_MAX_CYC (`PBP_TOPW_MAX_US * `PBP_CLK_MHZ)
// Setup and hold times of 2 us
`define PBP_TSET_US 2
`define PBP_TSET_CYC (`PBP_TSET_US * `PBP_CLK_MHZ)
// Data output delay 150 ns, rounded up
`define PBP_TOE_NS 150
`define PBP_TOE_CYC ((`PBP_TOE_NS * `PBP_CLK_MHZ + 999) / 1000)
// Pulse attempts before a byte is declared failed
`define PBP_MAX_TRY 25
`define PBP_TW 21
`define PBP_NW 5

`endif

// [core/pbp_timer.v]
/*
  Down counter used by the programmer for every timed pin phase.
  Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module pbp_timer (
  input wire i_sys_clk,
  input wire i_srst,
  input wire i_ce,
  input wire i_load,
  input wire [20:0] i_count,
  output reg o_done
);

  reg [20:0] cnt;

  // Load a count, then pulse done for one cycle when it reaches zero;
  // a held done would let the next phase end on its first cycle
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      cnt <= 21'h00_0000;
      o_done <= 1'b0;
    end else if (i_ce) begin
      if (i_load) begin
        cnt <= i_count;
        o_done <= 1'b0;
      end else if (cnt != 21'h00_0000) begin
        cnt <= cnt - 21'h00_0001;
        o_done <= (cnt == 21'h00_0001);
      end else begin
        o_done <= 1'b0;
      end
    end
  end

endmodule // pbp_timer
`default_nettype wire

// [core/pbp_host.v]
/*
  Byte-at-a-time high-speed PROM programmer: holds the PROM mode pins,
  drives address, data, chip enable, output enable and program strobe,
  and runs pulse, verify and overwrite per byte.
  Assumes the user holds i_addr and i_data stable during a request.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pbp_map.vh"
module pbp_host (
  input wire i_sys_clk,
  input wire i_srst,
  input wire i_ce,
  input wire i_start,
  input wire i_read,
  input wire i_sel_32k,
  input wire [16:0] i_addr,
  input wire [7:0] i_data,
  input wire [7:0] i_prog_data_bus,
  output reg o_busy,
  output reg o_done,
  output reg o_fail,
  output reg [7:0] o_rdata,
  output reg o_mode_select_hi,
  output reg o_mode_select_lo,
  output reg o_hw_standby_n,
  output reg o_prom_select_a,
  output reg o_prom_select_b,
  output reg o_chip_enable_n,
  output reg o_output_enable_n,
  output reg o_program_strobe_n,
  output reg [16:0] o_prog_address_bus,
  output reg [7:0] o_prog_data_bus,
  output reg o_prog_data_oe
);

  // ****************************************************************
  // States and storage
  // ****************************************************************
  localparam ST_IDLE = 3'd0;
  localparam ST_SETUP = 3'd1;
  localparam ST_PULSE = 3'd2;
  localparam ST_VSET = 3'd3;
  localparam ST_VREAD = 3'd4;
  localparam ST_OVER = 3'd5;
  localparam ST_HOLD = 3'd6;
  localparam ST_OSET = 3'd7;

  reg [2:0] state;
  reg [4:0] tries;
  reg is_read;
  reg [7:0] wbyte;
  reg [7:0] sync1;
  reg [7:0] sync2;
  reg tload;
  reg [20:0] tcount;
  wire tdone;
  wire [16:0] top_addr;
  wire [31:0] over_full;
  wire [20:0] over_cyc;
  wire [20:0] over_max;

  // Timing counts kept at full width, then cut to the timer's 21 bits
  localparam [31:0] TSET_W = `PBP_TSET_CYC;
  localparam [31:0] TPW_W = `PBP_TPW_CYC;
  localparam [31:0] OMIN_W = `PBP_TOPW_MIN_CYC;
  localparam [31:0] OMAX_W = `PBP_TOPW_MAX_CYC;
  localparam [31:0] TRY_W = `PBP_MAX_TRY;

  // Overwrite grows with the attempts; even 25 stay under the maximum
  assign over_full = OMIN_W * {27'h000_0000, tries};
  assign over_cyc = over_full[20:0];
  assign over_max = OMAX_W[20:0];
  assign top_addr = i_sel_32k ? `PBP_TOP_32K : `PBP_TOP_48K;

  pbp_timer u_timer (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_load(tload),
    .i_count(tcount),
    .o_done(tdone)
  );

  // ****************************************************************
  // Read data synchroniser
  // ****************************************************************
  // Bus comes from the device pins, so two flops before use
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else if (i_ce) begin
      sync1 <= i_prog_data_bus;
      sync2 <= sync1;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // One byte per request; no page sequence is ever issued
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      state <= ST_IDLE;
      tries <= 5'h00;
      is_read <= 1'b0;
      wbyte <= `PBP_FILL;
      tload <= 1'b0;
      tcount <= 21'h00_0000;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_fail <= 1'b0;
      o_rdata <= 8'h00;
      o_mode_select_hi <= 1'b0;
      o_mode_select_lo <= 1'b0;
      o_hw_standby_n <= 1'b0;
      o_prom_select_a <= 1'b1;
      o_prom_select_b <= 1'b1;
      o_chip_enable_n <= 1'b1;
      o_output_enable_n <= 1'b1;
      o_program_strobe_n <= 1'b1;
      o_prog_address_bus <= 17'h0_0000;
      o_prog_data_bus <= `PBP_FILL;
      o_prog_data_oe <= 1'b0;
    end else if (i_ce) begin
      // PROM mode straps held for the whole session
      o_mode_select_hi <= 1'b0;
      o_mode_select_lo <= 1'b0;
      o_hw_standby_n <= 1'b0;
      o_prom_select_a <= 1'b1;
      o_prom_select_b <= 1'b1;
      tload <= 1'b0;
      o_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Idle pins: chip disabled, data floated, inhibit
          o_chip_enable_n <= 1'b1;
          o_output_enable_n <= 1'b1;
          o_program_strobe_n <= 1'b1;
          o_prog_data_oe <= 1'b0;
          if (i_start) begin
            o_busy <= 1'b1;
            o_fail <= 1'b0;
            tries <= 5'h00;
            is_read <= i_read;
            o_prog_address_bus <= i_addr;
            // Outside the array only all-ones is written
            if (i_addr > top_addr)
              wbyte <= `PBP_FILL;
            else
              wbyte <= i_data;
            if (i_addr > top_addr)
              o_prog_data_bus <= `PBP_FILL;
            else
              o_prog_data_bus <= i_data;
            o_prog_data_oe <= ~i_read;
            o_chip_enable_n <= 1'b0;
            tcount <= TSET_W[20:0];
            tload <= 1'b1;
            state <= i_read ? ST_VSET : ST_SETUP;
          end
        end
        ST_SETUP: begin
          // Address and data settle before the strobe falls
          if (tdone) begin
            o_program_strobe_n <= 1'b0;
            tries <= tries + 5'h01;
            tcount <= TPW_W[20:0];
            tload <= 1'b1;
            state <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          // End of program pulse, strobe high, keep data driven for the hold time
          if (tdone) begin
            o_program_strobe_n <= 1'b1;
            tcount <= TSET_W[20:0];
            tload <= 1'b1;
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // Data hold after strobe, then float data for verify
          if (tdone) begin
            o_prog_data_oe <= 1'b0;
            tcount <= TSET_W[20:0];
            tload <= 1'b1;
            state <= ST_VSET;
          end
        end
        ST_VSET: begin
          // Output enable low with strobe high reads back
          if (tdone) begin
            o_output_enable_n <= 1'b0;
            tcount <= TSET_W[20:0];
            tload <= 1'b1;
            state <= ST_VREAD;
          end
        end
        ST_VREAD: begin
          // Sample long after output delay, past the synchroniser
          if (tdone) begin
            o_output_enable_n <= 1'b1;
            o_rdata <= sync2;
            if (is_read) begin
              o_busy <= 1'b0;
              o_done <= 1'b1;
              o_chip_enable_n <= 1'b1;
              state <= ST_IDLE;
            end else if (sync2 == wbyte) begin
              // Match: drive data again, let it settle, then overwrite
              o_prog_data_oe <= 1'b1;
              tcount <= TSET_W[20:0];
              tload <= 1'b1;
              state <= ST_OSET;
            end else if (tries >= TRY_W[4:0]) begin
              o_fail <= 1'b1;
              o_busy <= 1'b0;
              o_done <= 1'b1;
              o_chip_enable_n <= 1'b1;
              state <= ST_IDLE;
            end else begin
              // Mismatch: drive data and pulse again
              o_prog_data_oe <= 1'b1;
              tcount <= TSET_W[20:0];
              tload <= 1'b1;
              state <= ST_SETUP;
            end
          end
        end
        ST_OSET: begin
          // Overwrite pulse, clamped into its legal window
          if (tdone) begin
            o_program_strobe_n <= 1'b0;
            if (over_cyc < OMIN_W[20:0])
              tcount <= OMIN_W[20:0];
            else if (over_cyc > over_max)
              tcount <= over_max;
            else
              tcount <= over_cyc;
            tload <= 1'b1;
            state <= ST_OVER;
          end
        end
        ST_OVER: begin
          // Overwrite pulse done, byte finished
          if (tdone) begin
            o_program_strobe_n <= 1'b1;
            o_busy <= 1'b0;
            o_done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // pbp_host
`default_nettype wire

// [bench/pbp_host_asserts.sv]
/* Pin-level assertions for the PROM programmer.
   Assumes it is bound onto pbp_host with one clock and sync reset. */
`timescale 1ns/1ns
`default_nettype none
module pbp_host_asserts (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_sel_32k,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_mode_select_hi,
  input wire logic o_mode_select_lo,
  input wire logic o_hw_standby_n,
  input wire logic o_prom_select_a,
  input wire logic o_prom_select_b,
  input wire logic o_chip_enable_n,
  input wire logic o_output_enable_n,
  input wire logic o_program_strobe_n,
  input wire logic [16:0] o_prog_address_bus,
  input wire logic [7:0] o_prog_data_bus,
  input wire logic o_prog_data_oe
);
  // ********
  // Pulse width
  // ********
  localparam int PW_MIN = 47500;
  localparam int PW_MAX = 1312500;
  logic [20:0] low_cnt;
  // Counter, since a repetition this long would choke the tools
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || o_program_strobe_n) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= low_cnt + 21'h1;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  straps_held_a: assert property (
    !o_mode_select_hi && !o_mode_select_lo && !o_hw_standby_n
    && o_prom_select_a && o_prom_select_b)
    else $error("mode straps wrong");
  start_taken_a: assert property (
    !o_busy && !o_done && i_start && i_ce |=> o_busy)
    else $error("start not taken");
  write_mode_a: assert property (
    !o_program_strobe_n |->
    !o_chip_enable_n && o_output_enable_n && o_prog_data_oe)
    else $error("strobe outside write");
  verify_mode_a: assert property (
    !o_output_enable_n |->
    !o_chip_enable_n && o_program_strobe_n && !o_prog_data_oe)
    else $error("verify with strobe or drive");
  pulse_width_a: assert property (
    $rose(o_program_strobe_n) |-> low_cnt >= PW_MIN && low_cnt <= PW_MAX)
    else $error("pulse width");
  fill_ones_a: assert property (
    o_prog_data_oe && o_busy
    && o_prog_address_bus > (i_sel_32k ? 17'h0_7FFF : 17'h0_BFFF)
    |-> o_prog_data_bus == 8'hFF)
    else $error("no fill above top");
  done_single_a: assert property (
    o_done |-> !o_busy ##1 !o_done)
    else $error("done not a pulse");
  addr_steady_a: assert property (
    o_busy && $past(o_busy) |-> $stable(o_prog_address_bus))
    else $error("address moved");
endmodule // pbp_host_asserts
`default_nettype wire

// [bench/pbp_prom_model.sv]
/* Behavioural PROM in programming mode, byte wide.
   Assumes the bench resolves the shared data pins. */
`timescale 1ns/1ns
`default_nettype none
module pbp_prom_model (
  input wire logic i_chip_enable_n,
  input wire logic i_output_enable_n,
  input wire logic i_program_strobe_n,
  input wire logic [16:0] i_prog_address_bus,
  input wire logic [7:0] i_prog_data_bus,
  output wire logic [7:0] o_prog_data_bus
);
  // ********
  // Array
  // ********
  logic [7:0] mem [0:131071];
  wire logic drive = !i_chip_enable_n && !i_output_enable_n
    && i_program_strobe_n;
  // Erased cells read all ones
  initial begin
    for (int k = 0; k < 131072; k++) mem[k] = 8'hFF;
  end
  // Cells only lose ones, as in a floating-gate array
  always @(negedge i_program_strobe_n) begin
    if (!i_chip_enable_n && i_output_enable_n) begin
      mem[i_prog_address_bus] = mem[i_prog_address_bus] & i_prog_data_bus;
    end
  end
  // Floating pins show the inverse so an early sample never passes
  assign o_prog_data_bus = drive ? mem[i_prog_address_bus]
    : ~mem[i_prog_address_bus];
endmodule // pbp_prom_model
`default_nettype wire

// [bench/prom_byte_program_port_test.sv]
/* Self-checking bench for pbp_host against the PROM model.
   Assumes full-length pin timing, so a program takes ~100k cycles. */
`timescale 1ns/1ns
`default_nettype none
module prom_byte_program_port_test;
  logic i_sys_clk = 0, i_srst = 1, i_ce = 1, i_start = 0, i_read = 1;
  logic i_sel_32k = 0;
  logic [16:0] i_addr = '0;
  logic [7:0] i_data = '0;
  wire logic o_busy, o_done, o_fail, o_mode_select_hi, o_mode_select_lo;
  wire logic o_hw_standby_n, o_prom_select_a, o_prom_select_b;
  wire logic o_chip_enable_n, o_output_enable_n, o_program_strobe_n;
  wire logic o_prog_data_oe;
  wire logic [7:0] o_rdata, o_prog_data_bus, dev_out;
  wire logic [16:0] o_prog_address_bus;
  // Host owns the pins while it drives them
  wire logic [7:0] bus_level = o_prog_data_oe ? o_prog_data_bus : dev_out;
  int errors = 0, tests_run = 0, cycles = 0;
  // Rows: 32K select, address, expected byte
  logic [25:0] rows [4] = '{{1'h0, 17'h0_0000, 8'h12},
    {1'h0, 17'h0_BFFF, 8'hA5}, {1'h1, 17'h0_7FFF, 8'hFF},
    {1'h0, 17'h1_FFFF, 8'hFF}};
  pbp_host uut (.i_sys_clk, .i_srst, .i_ce, .i_start, .i_read, .i_sel_32k,
    .i_addr, .i_data, .i_prog_data_bus(bus_level), .o_busy, .o_done,
    .o_fail, .o_rdata, .o_mode_select_hi, .o_mode_select_lo,
    .o_hw_standby_n, .o_prom_select_a, .o_prom_select_b, .o_chip_enable_n,
    .o_output_enable_n, .o_program_strobe_n, .o_prog_address_bus,
    .o_prog_data_bus, .o_prog_data_oe);
  pbp_prom_model dev (.i_chip_enable_n(o_chip_enable_n),
    .i_output_enable_n(o_output_enable_n),
    .i_program_strobe_n(o_program_strobe_n),
    .i_prog_address_bus(o_prog_address_bus), .i_prog_data_bus(bus_level),
    .o_prog_data_bus(dev_out));
  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  // Hang guard: one byte program is near 100k cycles, each read about 1k
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 120000) begin
      errors++;
      wrap_up;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task op(input logic rd, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    repeat (2) @(negedge i_sys_clk);
    i_read = rd;
    i_addr = a;
    i_data = d;
    i_start = 1;
    @(negedge i_sys_clk);
    i_start = 0;
    while (o_done !== 1'h1 && n < 110000) begin
      @(negedge i_sys_clk);
      n++;
    end
    check(o_done, 1'h1);
  endtask
  task wrap_up;
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge i_sys_clk);
    i_srst = 0;
    check({o_busy, o_done, o_fail, o_chip_enable_n, o_output_enable_n,
      o_program_strobe_n, o_prog_data_oe, o_rdata}, 15'h0E00);
    dev.mem[17'h0_0000] = 8'h12;
    dev.mem[17'h0_BFFF] = 8'hA5;
    foreach (rows[r]) begin
      i_sel_32k = rows[r][25];
      op(1'h1, rows[r][24:8], 8'h00);
      check(o_rdata, rows[r][7:0]);
    end
    // Above the 32K top the user byte must become all ones
    i_sel_32k = 1;
    op(1'h0, 17'h0_8000, 8'h00);
    check(dev.mem[17'h0_8000], 8'hFF);
    check(o_fail, 1'h0);
    check(o_rdata, 8'hFF);
    // A reset in mid-read drops the transfer at once
    repeat (2) @(negedge i_sys_clk);
    i_read = 1;
    i_addr = 17'h0_0000;
    i_start = 1;
    @(negedge i_sys_clk);
    i_start = 0;
    repeat (50) @(negedge i_sys_clk);
    i_srst = 1;
    @(negedge i_sys_clk);
    i_srst = 0;
    check({o_busy, o_chip_enable_n, o_output_enable_n}, 3'h3);
    // The first request after that reset must run normally
    op(1'h1, 17'h0_0000, 8'h00);
    check(o_rdata, 8'h12);
    wrap_up;
  end
endmodule // prom_byte_program_port_test
bind pbp_host pbp_host_asserts chk (.i_sys_clk, .i_srst, .i_ce, .i_start,
  .i_sel_32k, .o_busy, .o_done, .o_mode_select_hi, .o_mode_select_lo,
  .o_hw_standby_n, .o_prom_select_a, .o_prom_select_b, .o_chip_enable_n,
  .o_output_enable_n, .o_program_strobe_n, .o_prog_address_bus,
  .o_prog_data_bus, .o_prog_data_oe);
`default_nettype wire
